// *** hdl/ptc_pkg.sv ***
/*
 * Shared constants and types of the periodic timer capture/compare block.
 * Assumes a byte-wide register port; all offsets below are byte addresses.
 */
package ptc_pkg;

    localparam int PTC_AW = 4;
    localparam int PTC_DW = 8;
    localparam int PTC_MAX_W = 16;

    // Register offsets
    localparam logic [PTC_AW-1:0] OFS_RUN = 4'h0;
    localparam logic [PTC_AW-1:0] OFS_CTRL1 = 4'h1;
    localparam logic [PTC_AW-1:0] OFS_CTRL2 = 4'h2;
    localparam logic [PTC_AW-1:0] OFS_CAPB_LO = 4'h3;
    localparam logic [PTC_AW-1:0] OFS_CAPB_HI = 4'h4;
    localparam logic [PTC_AW-1:0] OFS_CNT_LO = 4'h5;
    localparam logic [PTC_AW-1:0] OFS_CNT_HI = 4'h6;
    localparam logic [PTC_AW-1:0] OFS_CMPA_LO = 4'h7;
    localparam logic [PTC_AW-1:0] OFS_CMPA_HI = 4'h8;
    localparam logic [PTC_AW-1:0] OFS_PER_LO = 4'h9;
    localparam logic [PTC_AW-1:0] OFS_PER_HI = 4'ha;

    // Field positions
    localparam int RUN_BIT = 0;
    localparam int MODE_LSB = 6;
    localparam int IO_LSB = 4;
    localparam int OC_BIT = 3;
    localparam int POL_BIT = 2;
    localparam int CAPTS_BIT = 1;
    localparam int CCLR_BIT = 0;
    localparam int TCLR_LSB = 1;
    localparam int VLF_BIT = 0;

    // Reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // Operating modes
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_CAP = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TC = 2'h3;

    // Pin function codes, compare / PWM / capture meanings
    localparam logic [1:0] IO_NONE = 2'h0;
    localparam logic [1:0] IO_LOW = 2'h1;
    localparam logic [1:0] IO_HIGH = 2'h2;
    localparam logic [1:0] IO_TOGGLE = 2'h3;
    localparam logic [1:0] IO_INACTIVE = 2'h0;
    localparam logic [1:0] IO_ACTIVE = 2'h1;
    localparam logic [1:0] IO_PWM = 2'h2;
    localparam logic [1:0] IO_PULSE = 2'h3;
    localparam logic [1:0] IO_CAP_RISE = 2'h0;
    localparam logic [1:0] IO_CAP_FALL = 2'h1;
    localparam logic [1:0] IO_CAP_BOTH = 2'h2;
    localparam logic [1:0] IO_CAP_OFF = 2'h3;

    // Capture clear conditions
    localparam logic [1:0] TCLR_P_ONLY = 2'h0;

    typedef struct packed {
        logic [PTC_AW-1:0] addr;
        logic [PTC_DW-1:0] wdata;
        logic wr;
        logic rd;
    } ptc_bus_req_type;

    typedef struct packed {
        logic run;
        logic run_d;
        logic [1:0] mode;
        logic [1:0] io;
        logic oc;
        logic pol;
        logic capts;
        logic cclr;
        logic [1:0] tclr;
        logic vlf;
        logic [15:0] compare_a_value;
        logic [15:0] second_capture_value;
        logic [15:0] period_compare_value;
        logic [15:0] count;
        logic out_lvl;
        logic pin_s1;
        logic pin_s2;
        logic ext_s1;
        logic ext_s2;
        logic src_prev;
        logic a_evt;
        logic p_evt;
        logic [7:0] rdata;
    } ptc_state_type;

endpackage

// *** hdl/ptc_timer.sv ***
/*
 * Periodic timer with comparators A and P, output pin control, capture
 * input and counter readback, reached over a byte-wide register port.
 * Assumes the capture and external clock pins are asynchronous and the
 * register master keeps one-cycle strobes, never both at once.
 */
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

// Operation
// - pin function bits pick capture edge
// - compare mode: level bit sets initial level
// - PWM mode: level bit sets active polarity
// - single pulse: level bit driven at run rise
// - level bit inert in timer/counter mode
// - invert bit flips output pin
// - source bit: capture pin or clock pin
// - clear select 1 clears on A match
// - clear select 0: P match or overflow
// - clear select ignored in other modes
// - capture clear field adds edge clears
// - read-only flag tells latching edge
// - unimplemented bits read zero
// - second capture register, two writable bytes
// - counter readable as low/high bytes
// - compare A writable as low/high bytes
// - mode field selects operating mode
// - compare A match drives pin per function
// - dual edge: falling to A, rising to B
module ptc_timer
    import ptc_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter bit HAS_CAPB = 1'b1
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Register port
    input wire ptc_bus_req_type bus_req,
    output logic [PTC_DW-1:0] rd_data,
    // Pins
    input wire logic capture_input_pin,
    input wire logic external_clock_pin,
    output logic timer_output_pin_o,
    output logic timer_output_pin_oe,
    // Match events
    output logic compare_a_match,
    output logic period_match
);

    localparam logic [15:0] CNT_MASK = 16'((32'h1 << CNT_W) - 32'h1);

    ptc_state_type s_reg;
    ptc_state_type s_next;

    logic src_now;
    logic rise_e;
    logic fall_e;
    logic run_rise;
    logic a_hit;
    logic p_hit;
    logic cap_on;
    logic want_r;
    logic want_f;

    function automatic logic [15:0] fit(input logic [15:0] v);
        fit = v & CNT_MASK;
    endfunction

    function automatic logic [7:0] hi_byte(input logic [15:0] v);
        logic [15:0] m;
        m = fit(v);
        hi_byte = m[15:8];
    endfunction

    function automatic logic [15:0] put_lo(input logic [15:0] v, input logic [7:0] b);
        put_lo = fit({v[15:8], b});
    endfunction

    function automatic logic [15:0] put_hi(input logic [15:0] v, input logic [7:0] b);
        put_hi = fit({b, v[7:0]});
    endfunction

    // Capture source and edges after synchronisers
    assign src_now = s_reg.capts ? s_reg.ext_s2 : s_reg.pin_s2;
    assign rise_e = src_now & ~s_reg.src_prev;
    assign fall_e = ~src_now & s_reg.src_prev;
    assign run_rise = s_reg.run & ~s_reg.run_d;

    // Comparators; a zero compare value never matches
    assign a_hit = s_reg.run && s_reg.compare_a_value != WORD_RST && s_reg.count == s_reg.compare_a_value;
    assign p_hit = s_reg.run && s_reg.period_compare_value != WORD_RST && s_reg.count == s_reg.period_compare_value;

    assign cap_on = s_reg.mode == MODE_CAP && s_reg.run;
    assign want_r = s_reg.io == IO_CAP_RISE || s_reg.io == IO_CAP_BOTH;
    assign want_f = s_reg.io == IO_CAP_FALL || s_reg.io == IO_CAP_BOTH;

    always_comb begin
        logic clr;
        logic dual;
        clr = 1'b0;
        dual = HAS_CAPB && s_reg.tclr != TCLR_P_ONLY;
        s_next = s_reg;
        s_next.a_evt = 1'b0;
        s_next.p_evt = 1'b0;
        s_next.rdata = BYTE_RST;
        s_next.run_d = s_reg.run;
        s_next.pin_s1 = capture_input_pin;
        s_next.pin_s2 = s_reg.pin_s1;
        s_next.ext_s1 = external_clock_pin;
        s_next.ext_s2 = s_reg.ext_s1;
        s_next.src_prev = src_now;

        // Register writes
        if (bus_req.wr) begin
            case (bus_req.addr)
                OFS_RUN: s_next.run = bus_req.wdata[RUN_BIT];
                OFS_CTRL1: begin
                    s_next.mode = bus_req.wdata[MODE_LSB +: 2];
                    s_next.io = bus_req.wdata[IO_LSB +: 2];
                    s_next.oc = bus_req.wdata[OC_BIT];
                    s_next.pol = bus_req.wdata[POL_BIT];
                    s_next.capts = bus_req.wdata[CAPTS_BIT];
                    s_next.cclr = bus_req.wdata[CCLR_BIT];
                end
                OFS_CTRL2: begin
                    if (HAS_CAPB) begin
                        s_next.tclr = bus_req.wdata[TCLR_LSB +: 2];
                    end
                end
                OFS_CAPB_LO: begin
                    if (HAS_CAPB) begin
                        s_next.second_capture_value = {s_reg.second_capture_value[15:8], bus_req.wdata};
                    end
                end
                OFS_CAPB_HI: begin
                    if (HAS_CAPB) begin
                        s_next.second_capture_value = {bus_req.wdata, s_reg.second_capture_value[7:0]};
                    end
                end
                OFS_CMPA_LO: s_next.compare_a_value = put_lo(s_reg.compare_a_value, bus_req.wdata);
                OFS_CMPA_HI: s_next.compare_a_value = put_hi(s_reg.compare_a_value, bus_req.wdata);
                OFS_PER_LO: s_next.period_compare_value = put_lo(s_reg.period_compare_value, bus_req.wdata);
                OFS_PER_HI: s_next.period_compare_value = put_hi(s_reg.period_compare_value, bus_req.wdata);
                default: ;
            endcase
        end

        // Register reads, shown the cycle after the strobe
        if (bus_req.rd) begin
            case (bus_req.addr)
                OFS_RUN: s_next.rdata = {7'h00, s_reg.run};
                OFS_CTRL1: s_next.rdata = {s_reg.mode, s_reg.io, s_reg.oc, s_reg.pol,
                    s_reg.capts, s_reg.cclr};
                OFS_CTRL2: s_next.rdata = HAS_CAPB ? {5'h00, s_reg.tclr, s_reg.vlf}
                    : BYTE_RST;
                OFS_CAPB_LO: s_next.rdata = HAS_CAPB ? s_reg.second_capture_value[7:0] : BYTE_RST;
                OFS_CAPB_HI: s_next.rdata = HAS_CAPB ? s_reg.second_capture_value[15:8] : BYTE_RST;
                OFS_CNT_LO: s_next.rdata = s_reg.count[7:0];
                OFS_CNT_HI: s_next.rdata = hi_byte(s_reg.count);
                OFS_CMPA_LO: s_next.rdata = s_reg.compare_a_value[7:0];
                OFS_CMPA_HI: s_next.rdata = hi_byte(s_reg.compare_a_value);
                OFS_PER_LO: s_next.rdata = s_reg.period_compare_value[7:0];
                OFS_PER_HI: s_next.rdata = hi_byte(s_reg.period_compare_value);
                default: s_next.rdata = BYTE_RST;
            endcase
        end

        // Mode-dependent clearing, output and capture
        case (s_reg.mode)
            MODE_CMP, MODE_TC: begin
                clr = s_reg.cclr ? a_hit : p_hit;
                s_next.a_evt = a_hit;
                s_next.p_evt = p_hit && !s_reg.cclr;
                if (s_reg.mode == MODE_CMP) begin
                    if (run_rise) begin
                        s_next.out_lvl = s_reg.oc;
                    end else if (a_hit) begin
                        case (s_reg.io)
                            IO_LOW: s_next.out_lvl = 1'b0;
                            IO_HIGH: s_next.out_lvl = 1'b1;
                            IO_TOGGLE: s_next.out_lvl = ~s_reg.out_lvl;
                            default: ;
                        endcase
                    end
                end
            end
            MODE_PWM: begin
                clr = p_hit;
                s_next.a_evt = a_hit;
                s_next.p_evt = p_hit;
                case (s_reg.io)
                    IO_INACTIVE: s_next.out_lvl = ~s_reg.oc;
                    IO_ACTIVE: s_next.out_lvl = s_reg.oc;
                    IO_PWM: s_next.out_lvl = (s_reg.count < s_reg.compare_a_value) ? s_reg.oc
                        : ~s_reg.oc;
                    IO_PULSE: begin
                        if (run_rise) begin
                            s_next.out_lvl = s_reg.oc;
                        end else if (a_hit) begin
                            s_next.out_lvl = ~s_reg.oc;
                        end
                    end
                    default: ;
                endcase
            end
            MODE_CAP: begin
                clr = p_hit;
                s_next.p_evt = p_hit;
                if (cap_on && s_reg.io != IO_CAP_OFF) begin
                    if (rise_e && want_r) begin
                        if (dual) begin
                            s_next.second_capture_value = s_reg.count;
                            s_next.vlf = 1'b1;
                        end else begin
                            s_next.compare_a_value = s_reg.count;
                        end
                        s_next.a_evt = 1'b1;
                    end
                    if (fall_e && want_f) begin
                        s_next.compare_a_value = s_reg.count;
                        if (dual) begin
                            s_next.vlf = 1'b0;
                        end
                        s_next.a_evt = 1'b1;
                    end
                end
                if (cap_on && HAS_CAPB) begin
                    if ((rise_e && s_reg.tclr[0]) || (fall_e && s_reg.tclr[1])) begin
                        clr = 1'b1;
                    end
                end
            end
            default: ;
        endcase

        // Counter; wrap at the width mask gives the overflow clear
        if (run_rise) begin
            s_next.count = WORD_RST;
        end else if (s_reg.run) begin
            s_next.count = clr ? WORD_RST : fit(s_reg.count + 16'h0001);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign rd_data = s_reg.rdata;
    assign timer_output_pin_o = s_reg.out_lvl ^ s_reg.pol;
    assign timer_output_pin_oe = s_reg.run && s_reg.mode != MODE_TC;
    assign compare_a_match = s_reg.a_evt;
    assign period_match = s_reg.p_evt;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    tc_pin_off_a: assert property (s_reg.mode == MODE_TC |-> !timer_output_pin_oe)
        else $error("output driven in timer/counter mode");

    pin_invert_a: assert property (clk_en && s_reg.mode == MODE_CMP && run_rise
        && !bus_req.wr |=> timer_output_pin_o == ($past(s_reg.oc) ^ $past(s_reg.pol)))
        else $error("output pin polarity wrong after start");

    cmp_initial_a: assert property (clk_en && s_reg.mode == MODE_CMP && run_rise
        |=> s_reg.out_lvl == $past(s_reg.oc))
        else $error("compare initial level wrong");

    cmp_toggle_a: assert property (clk_en && s_reg.mode == MODE_CMP && a_hit && !run_rise
        && s_reg.io == IO_TOGGLE |=> s_reg.out_lvl != $past(s_reg.out_lvl))
        else $error("compare toggle missed");

    clear_on_a_a: assert property (clk_en && s_reg.mode == MODE_CMP && s_reg.cclr
        && a_hit && !run_rise |=> s_reg.count == WORD_RST)
        else $error("counter not cleared on A match");

    clear_on_p_a: assert property (clk_en && s_reg.mode == MODE_CMP && !s_reg.cclr
        && p_hit && !run_rise |=> s_reg.count == WORD_RST)
        else $error("counter not cleared on P match");

    pwm_level_a: assert property (clk_en && s_reg.mode == MODE_PWM && s_reg.io == IO_PWM
        && !bus_req.wr |=> s_reg.out_lvl == ($past(s_reg.count) < $past(s_reg.compare_a_value)
        ? $past(s_reg.oc) : !$past(s_reg.oc)))
        else $error("pwm level wrong");

    dual_rise_a: assert property (clk_en && cap_on && HAS_CAPB && s_reg.tclr != TCLR_P_ONLY
        && rise_e && want_r && s_reg.io != IO_CAP_OFF
        |=> s_reg.second_capture_value == $past(s_reg.count) && s_reg.vlf)
        else $error("rising capture not in second register");

    edge_clear_a: assert property (clk_en && cap_on && HAS_CAPB && rise_e && s_reg.tclr[0]
        && !run_rise |=> s_reg.count == WORD_RST)
        else $error("edge clear missed");

    cap_off_a: assert property (clk_en && s_reg.mode == MODE_CAP && s_reg.io == IO_CAP_OFF
        && !bus_req.wr |=> $stable(s_reg.compare_a_value) && $stable(s_reg.second_capture_value))
        else $error("capture while disabled");

    ctrl2_zero_a: assert property (clk_en && bus_req.rd && bus_req.addr == OFS_CTRL2
        |=> rd_data[7:3] == 5'h00)
        else $error("unimplemented bits not zero");

endmodule // ptc_timer

// *** tb/ptc_pin_model.sv ***
/*
 * Pin-side partner of the timer: drives the capture and external clock
 * pins on bench request and resolves the level of the timer output pin.
 * Assumes one ref_clk domain; pin changes land just after a rising edge.
 */
`timescale 1ns/1ps
module ptc_pin_model (
    // Clock
    input wire logic ref_clk,
    // From the timer
    input wire logic pin_o,
    input wire logic pin_oe,
    // To the timer and the bench
    output logic capture_input_pin,
    output logic external_clock_pin,
    output logic pin_level
);
    logic last_lvl = 1'b0;
    initial begin
        capture_input_pin = 1'b0;
        external_clock_pin = 1'b0;
    end
    // Released pin shows the opposite of its last driven level
    always @(posedge ref_clk) begin
        if (pin_oe) begin
            last_lvl <= pin_o;
        end
    end
    assign pin_level = pin_oe ? pin_o : ~last_lvl;
    task automatic set_pins(input logic cap, input logic ext);
        @(posedge ref_clk);
        capture_input_pin <= cap;
        external_clock_pin <= ext;
    endtask
endmodule // ptc_pin_model

// *** tb/periodic_timer_capture_compare_test.sv ***
/*
 * Self-checking bench of the timer: a wide timer with the second capture
 * register and a narrow one share the register port and the pins.
 * Assumes the register port and hand-over timing of ptc_timer.
 */
`timescale 1ns/1ps
module periodic_timer_capture_compare_test;
    import ptc_pkg::*;
    logic ref_clk = 1'b0;
    logic clk_en = 1'b1;
    logic reset_n = 1'b0;
    ptc_bus_req_type bus_req = '0;
    logic [PTC_DW-1:0] rd_w, rd_n;
    logic pin_o, pin_oe, a_w, p_w, a_n, cap_pin, ext_pin, pin_level;
    int err_total = 0;
    int compares = 0;
    logic [15:0] va, vb;
    int g_a, g_p, n;

    always #2.5 ref_clk = ~ref_clk;

    ptc_timer #(.CNT_W(16), .HAS_CAPB(1'b1)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
        .clk_en(clk_en), .bus_req(bus_req), .rd_data(rd_w), .capture_input_pin(cap_pin),
        .external_clock_pin(ext_pin), .timer_output_pin_o(pin_o),
        .timer_output_pin_oe(pin_oe), .compare_a_match(a_w), .period_match(p_w));
    ptc_timer #(.CNT_W(10), .HAS_CAPB(1'b0)) DUT_NARROW (.ref_clk(ref_clk),
        .reset_n(reset_n), .clk_en(clk_en), .bus_req(bus_req), .rd_data(rd_n),
        .capture_input_pin(cap_pin), .external_clock_pin(ext_pin),
        .timer_output_pin_o(), .timer_output_pin_oe(), .compare_a_match(a_n),
        .period_match());
    ptc_pin_model PM (.ref_clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .capture_input_pin(cap_pin), .external_clock_pin(ext_pin), .pin_level(pin_level));

    task automatic test_done();
        $display("Counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input bit nar, output logic [7:0] d);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        d = nar ? rd_n : rd_w;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e, input bit nar);
        logic [7:0] d;
        rd(a, nar, d);
        chk({8'h00, d}, {8'h00, e});
    endtask
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        rd(a, 1'b0, v[7:0]);
        rd(a + 4'h1, 1'b0, v[15:8]);
    endtask
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 4'h1, v[15:8]);
    endtask
    // Stop, set control1, restart, let the run rise settle
    task automatic cfg(input logic [1:0] m, io, input logic oc, pol, src, clr);
        wr(OFS_RUN, 8'h00);
        wr(OFS_CTRL1, {m, io, oc, pol, src, clr});
        wr(OFS_RUN, 8'h01);
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    // Cycles to the next pulse of the chosen event, 0 if none within lim
    task automatic wait_ev(input int sel, input int lim, input bit must, output int cyc);
        cyc = 0;
        for (int i = 1; i <= lim && cyc == 0; i++) begin
            @(posedge ref_clk);
            #1;
            if ((sel == 0 && a_w === 1'b1) || (sel == 1 && p_w === 1'b1)
                || (sel == 2 && a_n === 1'b1)) begin
                cyc = i;
            end
        end
        if (must && cyc == 0) begin
            err_total++;
            $display("MISMATCH t=%0t no pulse on event %0d", $time, sel);
            test_done();
        end
    endtask
    task automatic gap(input int sel, output int g);
        int t;
        wait_ev(sel, 2000, 1'b1, t);
        wait_ev(sel, 2000, 1'b1, g);
    endtask
    // Pin change, then the latch edge flag seven edges later
    task automatic pin_edge(input logic cap, ext, input logic [7:0] exp);
        PM.set_pins(cap, ext);
        repeat (5) @(posedge ref_clk);
        rdc(OFS_CTRL2, exp, 1'b0);
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            rdc(4'(a), 8'h00, 1'b0);
            rdc(4'(a), 8'h00, 1'b1);
        end
        wr(OFS_CTRL2, 8'hff);
        rdc(OFS_CTRL2, 8'h06, 1'b0);
        rdc(OFS_CTRL2, 8'h00, 1'b1);
        wr16(OFS_CAPB_LO, 16'h5aa5);
        rdc(OFS_CAPB_LO, 8'ha5, 1'b0);
        rdc(OFS_CAPB_HI, 8'h5a, 1'b0);
        wr16(OFS_CMPA_LO, 16'hff3c);
        rdc(OFS_CMPA_HI, 8'hff, 1'b0);
        rdc(OFS_CMPA_HI, 8'h03, 1'b1);
        rdc(OFS_CMPA_LO, 8'h3c, 1'b1);
        wr(OFS_CNT_LO, 8'hff);
        wr(4'hf, 8'hff);
        rdc(OFS_CNT_LO, 8'h00, 1'b0);
        rdc(4'hf, 8'h00, 1'b0);
        wr(OFS_CTRL2, 8'h00);
        $display("test registers done");
        wr16(OFS_CMPA_LO, 16'h0005);
        wr16(OFS_PER_LO, 16'h0003);
        cfg(MODE_TC, IO_NONE, 1'b0, 1'b0, 1'b0, 1'b1);
        gap(0, g_a);
        chk(16'(g_a), 16'h0006);
        wait_ev(1, 30, 1'b0, n);
        chk(16'(n), 16'h0000);
        wr16(OFS_PER_LO, 16'h0009);
        cfg(MODE_TC, IO_NONE, 1'b0, 1'b0, 1'b0, 1'b0);
        gap(1, g_p);
        chk(16'(g_p - g_a), 16'h0004);
        cfg(MODE_PWM, IO_PWM, 1'b0, 1'b0, 1'b0, 1'b1);
        gap(0, n);
        chk(16'(n), 16'(g_p));
        wr16(OFS_PER_LO, 16'h0000);
        cfg(MODE_TC, IO_NONE, 1'b0, 1'b0, 1'b0, 1'b0);
        gap(2, n);
        chk(16'(n), 16'h0400);
        // Ten frozen edges out of thirteen between the two counter samples
        rd(OFS_CNT_LO, 1'b0, va[7:0]);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (10) @(posedge ref_clk);
        clk_en <= 1'b1;
        rd(OFS_CNT_LO, 1'b0, vb[7:0]);
        chk({8'h00, vb[7:0] - va[7:0]}, 16'h0003);
        $display("test counter clear done");
        wr16(OFS_CMPA_LO, 16'h0028);
        for (int i = 0; i < 4; i++) begin
            cfg(MODE_CMP, 2'(i), 1'b1, i[1], 1'b0, 1'b1);
            chk({15'h0, pin_level}, {15'h0, ~i[1]});
            chk({15'h0, pin_oe}, 16'h0001);
            wait_ev(0, 100, 1'b1, n);
            repeat (2) @(posedge ref_clk);
            #1;
            chk({15'h0, pin_level}, {15'h0, ~i[0] ^ i[1]});
        end
        for (int j = 0; j < 4; j++) begin
            cfg(MODE_PWM, {1'b0, j[0]}, j[1], 1'b0, 1'b0, 1'b0);
            chk({15'h0, pin_level}, {15'h0, ~(j[0] ^ j[1])});
        end
        cfg(MODE_PWM, IO_PULSE, 1'b1, 1'b0, 1'b0, 1'b0);
        chk({15'h0, pin_level}, 16'h0001);
        wait_ev(0, 100, 1'b1, n);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({15'h0, pin_level}, 16'h0000);
        cfg(MODE_TC, IO_HIGH, 1'b1, 1'b1, 1'b0, 1'b0);
        chk({15'h0, pin_oe}, 16'h0000);
        $display("test output pin done");
        wr(OFS_CTRL2, 8'h06);
        cfg(MODE_CAP, IO_CAP_BOTH, 1'b0, 1'b0, 1'b0, 1'b0);
        pin_edge(1'b1, 1'b0, 8'h07);
        repeat (12) @(posedge ref_clk);
        pin_edge(1'b0, 1'b0, 8'h06);
        repeat (22) @(posedge ref_clk);
        pin_edge(1'b1, 1'b0, 8'h07);
        rd16(OFS_CMPA_LO, va);
        rd16(OFS_CAPB_LO, vb);
        chk(vb - va, 16'h000a);
        pin_edge(1'b1, 1'b1, 8'h07);
        pin_edge(1'b1, 1'b0, 8'h07);
        rd16(OFS_CMPA_LO, vb);
        chk(vb, va);
        pin_edge(1'b0, 1'b0, 8'h06);
        cfg(MODE_CAP, IO_CAP_RISE, 1'b0, 1'b0, 1'b1, 1'b0);
        pin_edge(1'b0, 1'b1, 8'h07);
        pin_edge(1'b0, 1'b0, 8'h07);
        cfg(MODE_CAP, IO_CAP_FALL, 1'b0, 1'b0, 1'b1, 1'b0);
        pin_edge(1'b0, 1'b1, 8'h07);
        pin_edge(1'b0, 1'b0, 8'h06);
        rd16(OFS_CMPA_LO, va);
        cfg(MODE_CAP, IO_CAP_OFF, 1'b0, 1'b0, 1'b1, 1'b0);
        pin_edge(1'b0, 1'b1, 8'h06);
        pin_edge(1'b0, 1'b0, 8'h06);
        rd16(OFS_CMPA_LO, vb);
        chk(vb, va);
        $display("test capture done");
        test_done();
    end
endmodule // periodic_timer_capture_compare_test
